/* hw/itc_core.sv */
module itc_core (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  // Host port
  input  wire logic                        csN,
  input  wire logic                        rdN,
  input  wire logic                        wrN,
  input  wire logic                        portSelectLo,
  input  wire logic                        portSelectHi,
  input  wire logic [itc_pkg::BYTE_W-1:0]  dataIn,
  output logic      [itc_pkg::BYTE_W-1:0]  dataOut,
  output logic                             dataOe,
  // Counter pins
  input  wire logic [itc_pkg::NUM_CNT-1:0] counterTickInput,
  input  wire logic [itc_pkg::NUM_CNT-1:0] counterGateInput,
  output logic      [itc_pkg::NUM_CNT-1:0] counterOutputPin
);
  import itc_pkg::*;

  typedef struct packed {
    logic [SYNC_N-1:0]               csSync;
    logic [SYNC_N-1:0]               rdSync;
    logic [SYNC_N-1:0]               wrSync;
    logic                            csLvl;
    logic                            rdLvl;
    logic                            wrLvl;
    logic [1:0]                      addrQ1;
    logic [1:0]                      addrQ2;
    logic [BYTE_W-1:0]               dataQ1;
    logic [BYTE_W-1:0]               dataQ2;
    logic [BYTE_W-1:0]               counterControlWord;
    logic [NUM_CNT-1:0][CFG_W-1:0]   cfg;
    logic [NUM_CNT-1:0][BYTE_W-1:0]  loadRegisterLow;
    logic [NUM_CNT-1:0][BYTE_W-1:0]  loadRegisterHigh;
    logic [NUM_CNT-1:0][BYTE_W-1:0]  readoutLatchLow;
    logic [NUM_CNT-1:0][BYTE_W-1:0]  readoutLatchHigh;
    logic [NUM_CNT-1:0][BYTE_W-1:0]  statusByte;
    logic [NUM_CNT-1:0]              writeHiNext;
    logic [NUM_CNT-1:0]              readHiNext;
    logic [NUM_CNT-1:0]              frozen;
    logic [NUM_CNT-1:0]              statusHeld;
    logic [NUM_CNT-1:0]              nullCount;
    logic [NUM_CNT-1:0]              loadReq;
    logic [NUM_CNT-1:0]              armReq;
    logic [BYTE_W-1:0]               dataOut;
    logic                            dataOe;
  } itc_core_state_t;

  // Strobes idle high, so a reset to zero would fake a strobe end
  localparam itc_core_state_t CORE_RESET = '{
    csSync: '1, rdSync: '1, wrSync: '1,
    csLvl: 1'b1, rdLvl: 1'b1, wrLvl: 1'b1,
    default: '0
  };
  localparam logic [1:0] CHECK_CNT = 2'h1;
  localparam logic [1:0] FIRST_CNT = 2'h0;

  itc_core_state_t            s_reg;
  itc_core_state_t            s_next;
  logic [NUM_CNT-1:0][CNT_W-1:0] cntValue;
  logic [NUM_CNT-1:0]         cntOut;
  logic [NUM_CNT-1:0]         cntDone;
  logic                       wrTake;
  logic                       rdTake;
  logic                       isCw;
  logic [1:0]                 addrNow;
  logic [BYTE_W-1:0]          dinNow;
  logic [1:0]                 selNow;
  logic [1:0]                 rwNow;

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  for (genvar g = 0; g < NUM_CNT; g++) begin : gCnt
    itc_counter uCnt (
      .mclk       (mclk),
      .rst_b      (rst_b),
      .tickPin    (counterTickInput[g]),
      .gatePin    (counterGateInput[g]),
      .bcdMode    (s_reg.cfg[g][BCD_BIT]),
      .loadStrobe (s_reg.loadReq[g]),
      .loadValue  ({s_reg.loadRegisterHigh[g], s_reg.loadRegisterLow[g]}),
      .armStrobe  (s_reg.armReq[g]),
      .countValue (cntValue[g]),
      .outLevel   (cntOut[g]),
      .loadDone   (cntDone[g])
    );
  end

  // ----------------------------------------
  // Host port and register logic
  // ----------------------------------------
  always_comb begin
    s_next         = s_reg;
    s_next.loadReq = '0;
    s_next.armReq  = '0;
    s_next.csSync  = {s_reg.csSync[SYNC_N-2:0], csN};
    s_next.rdSync  = {s_reg.rdSync[SYNC_N-2:0], rdN};
    s_next.wrSync  = {s_reg.wrSync[SYNC_N-2:0], wrN};
    // Address and data are held steady through a strobe, two stages suffice
    s_next.addrQ1  = {portSelectHi, portSelectLo};
    s_next.addrQ2  = s_reg.addrQ1;
    s_next.dataQ1  = dataIn;
    s_next.dataQ2  = s_reg.dataQ1;
    if (s_reg.csSync[SYNC_N-1] == s_reg.csSync[SYNC_N-2]) begin
      s_next.csLvl = s_reg.csSync[SYNC_N-1];
    end
    if (s_reg.rdSync[SYNC_N-1] == s_reg.rdSync[SYNC_N-2]) begin
      s_next.rdLvl = s_reg.rdSync[SYNC_N-1];
    end
    if (s_reg.wrSync[SYNC_N-1] == s_reg.wrSync[SYNC_N-2]) begin
      s_next.wrLvl = s_reg.wrSync[SYNC_N-1];
    end
    // Act at the trailing edge of a strobe, when data is surely settled
    wrTake  = s_next.wrLvl && !s_reg.wrLvl && !s_reg.csLvl;
    rdTake  = s_next.rdLvl && !s_reg.rdLvl && !s_reg.csLvl;
    addrNow = s_reg.addrQ2;
    dinNow  = s_reg.dataQ2;
    isCw    = (addrNow == ADDR_CW);
    selNow  = dinNow[COUNTER_SELECT_FIELD_HI:COUNTER_SELECT_FIELD_LO];
    rwNow   = dinNow[RW_HI:RW_LO];

    for (int i = 0; i < NUM_CNT; i++) begin
      if (!s_reg.frozen[i]) begin
        s_next.readoutLatchLow[i]  = cntValue[i][BYTE_W-1:0];
        s_next.readoutLatchHigh[i] = cntValue[i][CNT_W-1:BYTE_W];
      end
      if (cntDone[i]) begin
        s_next.nullCount[i] = 1'b0;
      end
    end

    // Control word write
    if (wrTake && isCw) begin
      s_next.counterControlWord = dinNow;
      if (selNow == READBACK_SELECT) begin
        for (int i = 0; i < NUM_CNT; i++) begin
          if (dinNow[RB_CNT_LO+i]) begin
            if (!dinNow[RB_NCOUNT]) begin
              s_next.frozen[i] = 1'b1;
            end
            if (!dinNow[RB_NSTATUS] && !s_reg.statusHeld[i]) begin
              s_next.statusByte[i] = {cntOut[i], s_reg.nullCount[i], s_reg.cfg[i]};
              s_next.statusHeld[i] = 1'b1;
            end
          end
        end
      end else if (rwNow == RW_LATCH) begin
        s_next.frozen[selNow] = 1'b1;
      end else begin
        s_next.cfg[selNow]              = dinNow[CFG_W-1:0];
        s_next.loadRegisterLow[selNow]  = BYTE_ZERO;
        s_next.loadRegisterHigh[selNow] = BYTE_ZERO;
        s_next.writeHiNext[selNow]      = 1'b0;
        s_next.readHiNext[selNow]       = 1'b0;
        s_next.frozen[selNow]           = 1'b0;
        s_next.statusHeld[selNow]       = 1'b0;
        s_next.armReq[selNow]           = 1'b1;
      end
    end

    // Count byte write; a new count wins over a same-cycle null clear
    if (wrTake && !isCw) begin
      unique case (s_reg.cfg[addrNow][RW_HI:RW_LO])
        RW_LATCH: begin
        end
        RW_LSB: begin
          s_next.loadRegisterLow[addrNow] = dinNow;
          s_next.loadReq[addrNow]         = 1'b1;
          s_next.nullCount[addrNow]       = 1'b1;
        end
        RW_MSB: begin
          s_next.loadRegisterHigh[addrNow] = dinNow;
          s_next.loadReq[addrNow]          = 1'b1;
          s_next.nullCount[addrNow]        = 1'b1;
        end
        RW_BOTH: begin
          if (!s_reg.writeHiNext[addrNow]) begin
            s_next.loadRegisterLow[addrNow] = dinNow;
            s_next.writeHiNext[addrNow]     = 1'b1;
          end else begin
            s_next.loadRegisterHigh[addrNow] = dinNow;
            s_next.writeHiNext[addrNow]      = 1'b0;
            s_next.loadReq[addrNow]          = 1'b1;
            s_next.nullCount[addrNow]        = 1'b1;
          end
        end
      endcase
    end

    // Read completion: step byte order, release a frozen latch
    if (rdTake && !isCw) begin
      if (s_reg.statusHeld[addrNow]) begin
        s_next.statusHeld[addrNow] = 1'b0;
      end else begin
        unique case (s_reg.cfg[addrNow][RW_HI:RW_LO])
          RW_LATCH: begin
          end
          RW_LSB, RW_MSB: begin
            s_next.frozen[addrNow] = 1'b0;
          end
          RW_BOTH: begin
            s_next.readHiNext[addrNow] = !s_reg.readHiNext[addrNow];
            if (s_reg.readHiNext[addrNow]) begin
              s_next.frozen[addrNow] = 1'b0;
            end
          end
        endcase
      end
    end

    // Read byte; control word address reads as zero
    s_next.dataOut = BYTE_ZERO;
    if (!isCw) begin
      if (s_reg.statusHeld[addrNow]) begin
        s_next.dataOut = s_reg.statusByte[addrNow];
      end else begin
        unique case (s_reg.cfg[addrNow][RW_HI:RW_LO])
          RW_LATCH: s_next.dataOut = BYTE_ZERO;
          RW_LSB:   s_next.dataOut = s_reg.readoutLatchLow[addrNow];
          RW_MSB:   s_next.dataOut = s_reg.readoutLatchHigh[addrNow];
          RW_BOTH:  s_next.dataOut = s_reg.readHiNext[addrNow] ?
                                     s_reg.readoutLatchHigh[addrNow] :
                                     s_reg.readoutLatchLow[addrNow];
        endcase
      end
    end
    s_next.dataOe = !s_next.csLvl && !s_next.rdLvl;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_reg <= CORE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dataOut          = s_reg.dataOut;
  assign dataOe           = s_reg.dataOe;
  assign counterOutputPin = cntOut;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_csGate;
    @(posedge mclk) disable iff (!rst_b)
    s_reg.csLvl |=> $stable(s_reg.counterControlWord) && s_reg.loadReq == '0;
  endproperty
  a_csGate: assert property (p_csGate) else $error("strobe taken while deselected");

  property p_cwStore;
    @(posedge mclk) disable iff (!rst_b)
    wrTake && isCw |=> s_reg.counterControlWord == $past(dinNow);
  endproperty
  a_cwStore: assert property (p_cwStore) else $error("control word not stored");

  property p_cwTarget;
    @(posedge mclk) disable iff (!rst_b)
    wrTake && isCw && selNow == CHECK_CNT && rwNow != RW_LATCH
      |=> s_reg.cfg[CHECK_CNT] == $past(dinNow[CFG_W-1:0]);
  endproperty
  a_cwTarget: assert property (p_cwTarget) else $error("control word hit wrong counter");

  property p_oeSel;
    @(posedge mclk) disable iff (!rst_b)
    dataOe |-> !s_reg.csLvl && !s_reg.rdLvl;
  endproperty
  a_oeSel: assert property (p_oeSel) else $error("bus driven outside a read");

  property p_oneByte;
    @(posedge mclk) disable iff (!rst_b)
    wrTake && !isCw && addrNow == FIRST_CNT
      |=> !($changed(s_reg.loadRegisterLow[0]) && $changed(s_reg.loadRegisterHigh[0]));
  endproperty
  a_oneByte: assert property (p_oneByte) else $error("two load bytes in one write");

  property p_zeroOther;
    @(posedge mclk) disable iff (!rst_b)
    wrTake && isCw && selNow == CHECK_CNT && rwNow == RW_LSB
      |=> s_reg.loadRegisterHigh[1] == BYTE_ZERO ##1 s_reg.loadRegisterHigh[1] == BYTE_ZERO;
  endproperty
  a_zeroOther: assert property (p_zeroOther) else $error("unused byte not zero");

  property p_nullSet;
    @(posedge mclk) disable iff (!rst_b)
    s_reg.loadReq[0] |-> s_reg.nullCount[0];
  endproperty
  a_nullSet: assert property (p_nullSet) else $error("null count not set on write");

  // A same-cycle count write keeps the flag set, so leave that case out
  property p_nullClear;
    @(posedge mclk) disable iff (!rst_b)
    cntDone[0] && !(wrTake && !isCw && addrNow == FIRST_CNT) |=> !s_reg.nullCount[0];
  endproperty
  a_nullClear: assert property (p_nullClear) else $error("null count not cleared");

  property p_freeze;
    @(posedge mclk) disable iff (!rst_b)
    s_reg.frozen[0]
      |=> $stable(s_reg.readoutLatchLow[0]) && $stable(s_reg.readoutLatchHigh[0]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("latched count moved");

  property p_track;
    @(posedge mclk) disable iff (!rst_b)
    !s_reg.frozen[0]
      |=> {s_reg.readoutLatchHigh[0], s_reg.readoutLatchLow[0]} == $past(cntValue[0]);
  endproperty
  a_track: assert property (p_track) else $error("readout latch not following");

  c_cwWrite:    cover property (@(posedge mclk) disable iff (!rst_b) wrTake && isCw);
  c_loadDone:   cover property (@(posedge mclk) disable iff (!rst_b) cntDone[0]);
  c_frozenRead: cover property (@(posedge mclk) disable iff (!rst_b) rdTake && s_reg.frozen[0]);
  c_statusRead: cover property (@(posedge mclk) disable iff (!rst_b)
                                rdTake && s_reg.statusHeld[0]);

endmodule : itc_core

/* hw/itc_counter.sv */
module itc_counter (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  // Counter pins
  input  wire logic                     tickPin,
  input  wire logic                     gatePin,
  // Programming
  input  wire logic                     bcdMode,
  input  wire logic                     loadStrobe,
  input  wire logic [itc_pkg::CNT_W-1:0] loadValue,
  input  wire logic                     armStrobe,
  // Status
  output logic      [itc_pkg::CNT_W-1:0] countValue,
  output logic                          outLevel,
  output logic                          loadDone
);
  import itc_pkg::*;

  typedef struct packed {
    logic [SYNC_N-1:0] tickSync;
    logic [SYNC_N-1:0] gateSync;
    logic              tickLvl;
    logic              gateLvl;
    logic              loadPend;
    logic [CNT_W-1:0]  ce;
    logic              outLvl;
    logic              done;
  } itc_cnt_state_t;

  itc_cnt_state_t s_reg;
  itc_cnt_state_t s_next;
  logic           tickRise;

  // ----------------------------------------
  // Down-count step, binary or four decades
  // ----------------------------------------
  function automatic logic [CNT_W-1:0] itc_dec(input logic [CNT_W-1:0] v, input logic bcd);
    logic [CNT_W-1:0] r;
    logic             borrow;
    r      = v - 16'h0001;
    borrow = 1'b1;
    if (bcd) begin
      r = v;
      for (int d = 0; d < DIGITS; d++) begin
        if (borrow) begin
          if (v[d*NIB_W +: NIB_W] == NIB_ZERO) begin
            r[d*NIB_W +: NIB_W] = NIB_NINE;
          end else begin
            r[d*NIB_W +: NIB_W] = v[d*NIB_W +: NIB_W] - NIB_ONE;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction : itc_dec

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next          = s_reg;
    s_next.done     = 1'b0;
    s_next.tickSync = {s_reg.tickSync[SYNC_N-2:0], tickPin};
    s_next.gateSync = {s_reg.gateSync[SYNC_N-2:0], gatePin};
    // Pin level only moves once the two older stages agree
    if (s_reg.tickSync[SYNC_N-1] == s_reg.tickSync[SYNC_N-2]) begin
      s_next.tickLvl = s_reg.tickSync[SYNC_N-1];
    end
    if (s_reg.gateSync[SYNC_N-1] == s_reg.gateSync[SYNC_N-2]) begin
      s_next.gateLvl = s_reg.gateSync[SYNC_N-1];
    end
    tickRise = s_next.tickLvl & ~s_reg.tickLvl;
    if (loadStrobe) begin
      s_next.loadPend = 1'b1;
    end
    if (armStrobe) begin
      s_next.outLvl = 1'b0;
    end
    if (tickRise) begin
      if (s_reg.loadPend) begin
        s_next.ce       = loadValue;
        s_next.loadPend = loadStrobe;
        s_next.done     = 1'b1;
      end else if (s_reg.gateLvl) begin
        s_next.ce = itc_dec(s_reg.ce, bcdMode);
        if (s_next.ce == CNT_ZERO && !armStrobe) begin
          s_next.outLvl = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign countValue = s_reg.ce;
  assign outLevel   = s_reg.outLvl;
  assign loadDone   = s_reg.done;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_ceLoad;
    @(posedge mclk) disable iff (!rst_b)
    s_reg.loadPend && tickRise |=> s_reg.ce == $past(loadValue) && loadDone;
  endproperty
  a_ceLoad: assert property (p_ceLoad) else $error("count not moved into element");

  property p_ceDown;
    @(posedge mclk) disable iff (!rst_b)
    !s_reg.loadPend && tickRise && s_reg.gateLvl && !bcdMode
      |=> s_reg.ce == CNT_W'($past(s_reg.ce) - 16'h0001);
  endproperty
  a_ceDown: assert property (p_ceDown) else $error("element did not count down");

  property p_ceHold;
    @(posedge mclk) disable iff (!rst_b)
    !tickRise |=> $stable(s_reg.ce);
  endproperty
  a_ceHold: assert property (p_ceHold) else $error("element moved without a tick");

endmodule : itc_counter

/* hw/itc_pkg.sv */
package itc_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_CNT = 3;
  localparam int CNT_W   = 16;
  localparam int BYTE_W  = 8;
  localparam int CFG_W   = 6;
  localparam int SYNC_N  = 3;
  localparam int DIGITS  = 4;
  localparam int NIB_W   = 4;

  // ----------------------------------------
  // Addresses and control word fields
  // ----------------------------------------
  localparam logic [1:0] ADDR_CW                 = 2'h3;
  localparam int         COUNTER_SELECT_FIELD_HI = 7;
  localparam int         COUNTER_SELECT_FIELD_LO = 6;
  localparam int         RW_HI                   = 5;
  localparam int         RW_LO                   = 4;
  localparam int         MODE_HI                 = 3;
  localparam int         MODE_LO                 = 1;
  localparam int         BCD_BIT                 = 0;
  localparam logic [1:0] READBACK_SELECT         = 2'h3;
  localparam logic [1:0] RW_LATCH                = 2'h0;
  localparam logic [1:0] RW_LSB                  = 2'h1;
  localparam logic [1:0] RW_MSB                  = 2'h2;
  localparam logic [1:0] RW_BOTH                 = 2'h3;

  // ----------------------------------------
  // Read-back command bits (count and status active low, counter select active high)
  // ----------------------------------------
  localparam int RB_NCOUNT  = 5;
  localparam int RB_NSTATUS = 4;
  localparam int RB_CNT_LO  = 1;

  // ----------------------------------------
  // Constant values
  // ----------------------------------------
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;
  localparam logic [NIB_W-1:0]  NIB_ZERO  = 4'h0;
  localparam logic [NIB_W-1:0]  NIB_NINE  = 4'h9;
  localparam logic [NIB_W-1:0]  NIB_ONE   = 4'h1;

endpackage : itc_pkg

/* tb/itc_host_model.sv */
module itc_host_model (
  // Clock
  input  wire logic                       mclk,
  // Host bus
  output logic                            csN,
  output logic                            rdN,
  output logic                            wrN,
  output logic                            portSelectLo,
  output logic                            portSelectHi,
  output logic      [itc_pkg::BYTE_W-1:0] dataIn,
  input  wire logic [itc_pkg::BYTE_W-1:0] dataOut,
  input  wire logic                       dataOe
);
  timeunit 1ns;
  timeprecision 100ps;
  import itc_pkg::*;

  logic              hostDrv;
  logic [BYTE_W-1:0] hostData;
  logic [BYTE_W-1:0] busLast;

  // Undriven bus toggles so a stale byte never passes for data
  assign dataIn = hostDrv ? hostData : (dataOe ? dataOut : ~busLast);

  always @(posedge mclk) busLast <= dataIn;

  initial begin
    csN = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
    {portSelectHi, portSelectLo} = 2'h0;
    hostDrv = 1'b0;
    hostData = 8'h00;
  end

  task automatic bus_write(input logic [1:0] a, input logic [BYTE_W-1:0] d, input logic sel);
    @(posedge mclk);
    {portSelectHi, portSelectLo} <= a;
    hostData <= d;
    hostDrv  <= 1'b1;
    csN      <= ~sel;
    wrN      <= 1'b0;
    repeat (8) @(posedge mclk);
    wrN <= 1'b1;
    // Address and data outlive the strobe by five cycles, more than the sync depth
    repeat (5) @(posedge mclk);
    csN     <= 1'b1;
    hostDrv <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : bus_write

  task automatic bus_read(input logic [1:0] a, input logic sel,
                          output logic [BYTE_W-1:0] d, output logic ok);
    int i;
    ok = 1'b0;
    d  = 8'h00;
    @(posedge mclk);
    {portSelectHi, portSelectLo} <= a;
    csN <= ~sel;
    rdN <= 1'b0;
    for (i = 0; i < 12 && !ok; i++) begin
      @(negedge mclk);
      if (dataOe === 1'b1) begin
        ok = 1'b1;
        d  = dataOut;
      end
    end
    repeat (5) @(posedge mclk);
    rdN <= 1'b1;
    repeat (5) @(posedge mclk);
    csN <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : bus_read
endmodule : itc_host_model

/* tb/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import itc_pkg::*;

  logic                mclk;
  logic                rst_b;
  logic                csN;
  logic                rdN;
  logic                wrN;
  logic                pSelLo;
  logic                pSelHi;
  logic                dataOe;
  logic                okFlag;
  logic [BYTE_W-1:0]   dataIn;
  logic [BYTE_W-1:0]   dataOut;
  logic [BYTE_W-1:0]   rdVal;
  logic [NUM_CNT-1:0]  tick;
  logic [NUM_CNT-1:0]  gate;
  logic [NUM_CNT-1:0]  outPin;
  int                  errTotal;
  int                  cmpCount;

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  itc_core u_dut (.mclk(mclk), .rst_b(rst_b), .csN(csN), .rdN(rdN), .wrN(wrN),
    .portSelectLo(pSelLo), .portSelectHi(pSelHi), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .counterTickInput(tick), .counterGateInput(gate),
    .counterOutputPin(outPin));

  itc_host_model u_host (.mclk(mclk), .csN(csN), .rdN(rdN), .wrN(wrN),
    .portSelectLo(pSelLo), .portSelectHi(pSelHi), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic print_verdict();
    $display("Counts: %0d compares, %0d wrong", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : check_byte

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    u_host.bus_write(a, d, 1'b1);
  endtask : wr

  // Unselected reads must get no answer at all
  task automatic rd_chk(input logic [1:0] a, input logic sel, input logic [7:0] exp,
                        input string msg);
    u_host.bus_read(a, sel, rdVal, okFlag);
    if (sel && okFlag !== 1'b1) begin
      errTotal++;
      $display("wrong value at %0t: no answer to %s", $time, msg);
      print_verdict();
    end else begin
      check_byte(sel ? rdVal : {7'h00, okFlag}, exp, msg);
    end
  endtask : rd_chk

  task automatic tick_n(input int idx, input int n);
    repeat (n) begin
      @(posedge mclk);
      tick[idx] <= 1'b1;
      repeat (5) @(posedge mclk);
      tick[idx] <= 1'b0;
      repeat (5) @(posedge mclk);
    end
  endtask : tick_n

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    errTotal = 0;
    cmpCount = 0;
    rst_b = 1'b0;
    tick  = 3'h0;
    gate  = 3'h7;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    check_byte({4'h0, dataOe, outPin}, 8'h00, "idle after reset");
    $display("test reset done");

    wr(2'h3, 8'h30);
    wr(2'h0, 8'h34);
    wr(2'h0, 8'h12);
    wr(2'h3, 8'hE2);
    rd_chk(2'h0, 1'b1, 8'h70, "status before load");
    tick_n(0, 1);
    wr(2'h3, 8'hE2);
    rd_chk(2'h0, 1'b1, 8'h30, "status after load");
    tick_n(0, 3);
    wr(2'h3, 8'h00);
    tick_n(0, 2);
    rd_chk(2'h0, 1'b1, 8'h31, "latched low");
    rd_chk(2'h0, 1'b1, 8'h12, "latched high");
    rd_chk(2'h0, 1'b1, 8'h2F, "following low");
    rd_chk(2'h0, 1'b1, 8'h12, "following high");
    $display("test counter 0 done");

    // Stale high byte that the next control word must clear
    wr(2'h3, 8'h60);
    wr(2'h1, 8'hAB);
    wr(2'h3, 8'h50);
    wr(2'h1, 8'h07);
    wr(2'h3, 8'hA0);
    wr(2'h2, 8'h05);
    u_host.bus_write(2'h1, 8'h99, 1'b0);
    tick_n(1, 1);
    rd_chk(2'h1, 1'b1, 8'h07, "low only");
    tick_n(2, 2);
    rd_chk(2'h2, 1'b1, 8'h04, "high only");
    tick_n(1, 7);
    @(negedge mclk);
    check_byte({5'h00, outPin}, 8'h02, "terminal on counter 1 only");
    wr(2'h3, 8'h11);
    wr(2'h0, 8'h10);
    tick_n(0, 2);
    rd_chk(2'h0, 1'b1, 8'h09, "decimal step");
    $display("test counters 1 and 2 done");

    rd_chk(2'h0, 1'b0, 8'h00, "read without select");
    rd_chk(2'h3, 1'b1, 8'h00, "control word read");
    $display("test select and control read done");
    print_verdict();
  end
endmodule : tb_top
